// ### rtl/internal_oscillator_block_ctrl.sv
`timescale 1ns/1ps
`include "osc_block_regs.svh"

module internal_oscillator_block_ctrl #(
	parameter int SLEW_CYC = `SLEW_CYC // cycles per trim step
) (
	input  wire logic        sys_clk_i,      // 125 MHz clock
	input  wire logic        sys_rst_i,      // sync reset, high
	input  wire logic        psel_i,         // apb select
	input  wire logic        penable_i,      // apb enable
	input  wire logic        pwrite_i,       // apb write
	input  wire logic [7:0]  paddr_i,        // apb byte address
	input  wire logic [31:0] pwdata_i,       // apb write data
	output logic             pready_o,       // apb ready
	output logic [31:0]      prdata_o,       // apb read data
	output logic             pslverr_o,      // apb error
	input  wire logic [3:0]  fosc_cfg_i,     // primary osc config
	input  wire logic        put_en_i,       // power-up timer on
	input  wire logic        fscm_en_i,      // clock monitor on
	input  wire logic        wdt_en_i,       // watchdog on
	input  wire logic        two_speed_en_i, // two-speed start on
	input  wire logic        osc_input_pin_i,  // in pin level
	input  wire logic        osc_output_pin_i, // out pin level
	input  wire logic        port_a_bit7_dout_i, // port data
	input  wire logic        port_a_bit7_drv_i,  // port drives
	input  wire logic        port_a_bit6_dout_i, // port data
	input  wire logic        port_a_bit6_drv_i,  // port drives
	output logic             osc_input_pin_o,    // in pin drive
	output logic             osc_input_pin_oe_n_o,  // low: drive
	output logic             osc_output_pin_o,      // out pin drive
	output logic             osc_output_pin_oe_n_o, // low: drive
	output logic             port_a_bit7_din_o,  // synced pin
	output logic             port_a_bit6_din_o,  // synced pin
	output logic             dev_clk_o,          // block clock
	output logic             fast_src_en_o,      // fast on
	output logic             slow_src_en_o,      // slow rc on
	output logic             pll_active_o        // pll running
);

	osc_block_pkg::ctrl_state_t st;
	osc_block_pkg::ctrl_state_t next_st;

	logic        fast_tick;
	logic        slow_tick;
	logic [23:0] fast_inc;
	logic [23:0] target_inc;
	logic        pll_ok;
	logic        blk_used;
	logic        clkout_mode;
	logic        dual_mode;
	logic        apb_access;
	logic        src_tick;
	logic [8:0]  want_half;
	osc_block_pkg::src_t want_src;
	logic        want_pll;
	logic        applied;
	logic        fast_run;
	logic        slow_run;

	////////////////////////////////////////////////////////////////////
	// decode helpers

	// pll allowed only in internal modes and fast selects
	function automatic logic pll_allowed(
		input logic [3:0] fosc,
		input logic [2:0] fsel
	);
		logic int_cfg;
		int_cfg = (fosc == `FOSC_CLKOUT) || (fosc == `FOSC_DUAL_IO);
		return int_cfg && ((fsel == `FSEL_FAST) ||
			(fsel == `FSEL_HALF));
	endfunction

	// half period of the block clock in source ticks
	function automatic logic [8:0] half_ticks(
		input logic [2:0] fsel,
		input logic       lfss
	);
		logic [8:0] h;
		h = 9'h001;
		if (fsel == `FSEL_LOW) begin
			if (lfss) begin
				h = `LOW_DIV_HALF;
			end
		end else begin
			h = 9'h001 << (3'h7 - fsel);
		end
		return h;
	endfunction

	////////////////////////////////////////////////////////////////////
	// phase tick generators for both sources

	// a source keeps ticking until the divider has left it, else a
	// switch away would wait forever on a falling edge
	assign fast_run = st.fast_en ||
		(st.act_src == osc_block_pkg::SRC_FAST);
	assign slow_run = st.slow_en ||
		(st.act_src == osc_block_pkg::SRC_SLOW);

	phase_tick_gen u_fast (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.en_i      (fast_run),
		.inc_i     (fast_inc),
		.tick_o    (fast_tick)
	);

	// slow source runs off its own fixed step, trim never applies
	phase_tick_gen u_slow (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.en_i      (slow_run),
		.inc_i     (`SLOW_INC),
		.tick_o    (slow_tick)
	);

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_st = st;
		pll_ok = pll_allowed(fosc_cfg_i, st.fsel);
		clkout_mode = fosc_cfg_i == `FOSC_CLKOUT;
		dual_mode = fosc_cfg_i == `FOSC_DUAL_IO;
		blk_used = st.scs[1] ||
			((st.scs == 2'h0) && (clkout_mode || dual_mode));
		apb_access = psel_i && penable_i && !st.pready;
		// signed trim widened to a phase offset
		target_inc = `FAST_INC +
			24'(signed'({{19{st.trim[4]}}, st.trim}) *
			signed'({1'b0, `TRIM_STEP}));
		fast_inc = st.act_pll ? {st.cur_inc[21:0], 2'b00} :
			st.cur_inc;
		src_tick = (st.act_src == osc_block_pkg::SRC_FAST) ?
			fast_tick : slow_tick;
		want_half = half_ticks(st.fsel, st.lfss);
		want_pll = st.pll_enable_bit && pll_ok;
		want_src = osc_block_pkg::SRC_OFF;
		if (blk_used) begin
			if ((st.fsel == `FSEL_LOW) && !st.lfss) begin
				want_src = osc_block_pkg::SRC_SLOW;
			end else begin
				want_src = osc_block_pkg::SRC_FAST;
			end
		end
		applied = 1'b0;

		// apb slave, one wait cycle then answer
		next_st.pready = apb_access;
		next_st.pslverr = 1'b0;
		next_st.prdata = 8'h00;
		if (apb_access) begin
			if (paddr_i == `OSC_CTRL_OFS) begin
				next_st.prdata = {st.idle, st.fsel, 2'b00, st.scs};
				if (pwrite_i) begin
					next_st.idle = pwdata_i[`CTRL_IDLE_BIT];
					next_st.fsel =
						pwdata_i[`CTRL_FSEL_HI:`CTRL_FSEL_LO];
					next_st.scs = pwdata_i[`CTRL_SCS_HI:`CTRL_SCS_LO];
				end
			end else if (paddr_i == `OSC_TRIM_OFS) begin
				next_st.prdata = {st.lfss, st.pll_enable_bit && pll_ok, 1'b0,
					st.trim};
				if (pwrite_i) begin
					next_st.lfss = pwdata_i[`TRIM_LFSS_BIT];
					next_st.pll_enable_bit = pwdata_i[`TRIM_PLL_BIT] &&
						pll_ok;
					next_st.trim = pwdata_i[`TRIM_TUN_HI:`TRIM_TUN_LO];
				end
			end else if (paddr_i == `OSC_STAT_OFS) begin
				next_st.prdata = {3'h0, st.act_pll, st.slow_en,
					st.fast_en, clkout_mode, dual_mode};
			end else begin
				next_st.pslverr = 1'b1;
			end
		end

		// pll bit stays clear whenever it cannot run
		if (!pll_ok) begin
			next_st.pll_enable_bit = 1'b0;
		end

		// source enables
		next_st.fast_en = (st.fsel != `FSEL_LOW) || st.lfss;
		next_st.slow_en = (want_src == osc_block_pkg::SRC_SLOW) ||
			put_en_i || fscm_en_i || wdt_en_i ||
			two_speed_en_i;

		// slew the fast step one trim code per interval
		if (st.cur_inc == target_inc) begin
			next_st.slew_cnt = 12'h000;
		end else if (st.slew_cnt >= 12'(SLEW_CYC - 1)) begin
			next_st.slew_cnt = 12'h000;
			if (signed'(st.cur_inc) < signed'(target_inc)) begin
				next_st.cur_inc = st.cur_inc + `TRIM_STEP;
			end else begin
				next_st.cur_inc = st.cur_inc - `TRIM_STEP;
			end
		end else begin
			next_st.slew_cnt = st.slew_cnt + 12'h001;
		end

		// divider; changes take effect at a falling edge, or at once while the active source is off
		if (st.act_src == osc_block_pkg::SRC_OFF) begin
			next_st.dev_clk = 1'b0;
			next_st.div_cnt = 9'h000;
			applied = 1'b1;
		end else if (src_tick) begin
			if (st.div_cnt >= st.act_half - 9'h001) begin
				next_st.div_cnt = 9'h000;
				next_st.dev_clk = !st.dev_clk;
				applied = st.dev_clk;
			end else begin
				next_st.div_cnt = st.div_cnt + 9'h001;
			end
		end
		if (applied) begin
			next_st.act_src = want_src;
			next_st.act_half = want_half;
			next_st.act_pll = want_pll;
		end

		// instruction clock: toggle every second rising edge
		if (src_tick && !st.dev_clk &&
			(st.div_cnt >= st.act_half - 9'h001)) begin
			next_st.ins_cnt = !st.ins_cnt;
			if (st.ins_cnt) begin
				next_st.ins_clk = !st.ins_clk;
			end
		end

		// pin synchronisers, filtered when stages two and three agree
		next_st.in_sync = {st.in_sync[1:0], osc_input_pin_i};
		next_st.out_sync = {st.out_sync[1:0], osc_output_pin_i};
		if (st.in_sync[1] == st.in_sync[2]) begin
			next_st.in_filt = st.in_sync[2];
		end
		if (st.out_sync[1] == st.out_sync[2]) begin
			next_st.out_filt = st.out_sync[2];
		end

		// pin functions per configuration
		next_st.out_pin = 1'b0;
		next_st.out_oe_n = 1'b1;
		next_st.in_pin = 1'b0;
		next_st.in_oe_n = 1'b1;
		next_st.bit7_din = 1'b0;
		next_st.bit6_din = 1'b0;
		if (clkout_mode || dual_mode) begin
			next_st.in_pin = port_a_bit7_dout_i;
			next_st.in_oe_n = !port_a_bit7_drv_i;
			next_st.bit7_din = st.in_filt;
		end
		if (clkout_mode) begin
			next_st.out_pin = st.ins_clk;
			next_st.out_oe_n = 1'b0;
		end else if (dual_mode) begin
			next_st.out_pin = port_a_bit6_dout_i;
			next_st.out_oe_n = !port_a_bit6_drv_i;
			next_st.bit6_din = st.out_filt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
			st.fsel <= `CTRL_FSEL_RST;
			st.scs <= `CTRL_SCS_RST;
			st.cur_inc <= `FAST_INC;
			st.act_half <= 9'h001;
			st.act_src <= osc_block_pkg::SRC_OFF;
			st.in_oe_n <= 1'b1;
			st.out_oe_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register

	assign pready_o = st.pready;
	assign prdata_o = {24'h000000, st.prdata};
	assign pslverr_o = st.pslverr;
	assign osc_input_pin_o = st.in_pin;
	assign osc_input_pin_oe_n_o = st.in_oe_n;
	assign osc_output_pin_o = st.out_pin;
	assign osc_output_pin_oe_n_o = st.out_oe_n;
	assign port_a_bit7_din_o = st.bit7_din;
	assign port_a_bit6_din_o = st.bit6_din;
	assign dev_clk_o = st.dev_clk;
	assign fast_src_en_o = st.fast_en;
	assign slow_src_en_o = st.slow_en;
	assign pll_active_o = st.act_pll;

endmodule

// ### shared/osc_block_regs.svh
`ifndef OSC_BLOCK_REGS_SVH
`define OSC_BLOCK_REGS_SVH

// register byte offsets
`define OSC_CTRL_OFS   8'h00
`define OSC_TRIM_OFS   8'h04
`define OSC_STAT_OFS   8'h08

// control register fields
`define CTRL_IDLE_BIT  7
`define CTRL_FSEL_HI   6
`define CTRL_FSEL_LO   4
`define CTRL_SCS_HI    1
`define CTRL_SCS_LO    0
`define CTRL_FSEL_RST  3'h4
`define CTRL_SCS_RST   2'h0

// trim register fields
`define TRIM_LFSS_BIT  7
`define TRIM_PLL_BIT   6
`define TRIM_TUN_HI    4
`define TRIM_TUN_LO    0

// primary oscillator configuration codes
`define FOSC_CLKOUT    4'h9
`define FOSC_DUAL_IO   4'h8

// select codes
`define FSEL_FAST      3'h7
`define FSEL_HALF      3'h6
`define FSEL_LOW       3'h0
`define LOW_DIV_HALF   9'h100

// timing: sys clock, sources, settle time
`define SYS_CLK_KHZ    125000
`define FAST_KHZ       8000
`define SLOW_HZ        31000
`define SETTLE_US      1000
`define SETTLE_CYC     (`SETTLE_US * (`SYS_CLK_KHZ / 1000))
`define SLEW_CYC       (`SETTLE_CYC / 32)

// phase increments, ticks at twice each source frequency
`define FAST_INC \
	24'((64'd2 * `FAST_KHZ * 64'd16777216) / `SYS_CLK_KHZ)
`define SLOW_INC \
	24'((64'd2 * `SLOW_HZ * 64'd16777216) / (`SYS_CLK_KHZ * 1000))
`define TRIM_STEP      24'h008000

`endif

// ### shared/osc_block_pkg.sv
package osc_block_pkg;

	typedef enum logic [1:0] {
		SRC_OFF  = 2'b00,
		SRC_FAST = 2'b01,
		SRC_SLOW = 2'b10
	} src_t;

	typedef struct packed {
		logic [23:0] acc;
		logic        tick;
	} tick_state_t;

	typedef struct packed {
		logic        idle;
		logic [2:0]  fsel;
		logic [1:0]  scs;
		logic        lfss;
		logic        pll_enable_bit;
		logic [4:0]  trim;
		logic [23:0] cur_inc;
		logic [11:0] slew_cnt;
		logic [2:0]  in_sync;
		logic        in_filt;
		logic [2:0]  out_sync;
		logic        out_filt;
		logic        pready;
		logic        pslverr;
		logic [7:0]  prdata;
		src_t        act_src;
		logic [8:0]  act_half;
		logic        act_pll;
		logic [8:0]  div_cnt;
		logic        dev_clk;
		logic        ins_cnt;
		logic        ins_clk;
		logic        fast_en;
		logic        slow_en;
		logic        out_pin;
		logic        out_oe_n;
		logic        in_pin;
		logic        in_oe_n;
		logic        bit7_din;
		logic        bit6_din;
	} ctrl_state_t;

endpackage

// ### rtl/phase_tick_gen.sv
`timescale 1ns/1ps
`include "osc_block_regs.svh"

module phase_tick_gen (
	input  wire logic        sys_clk_i, // system clock
	input  wire logic        sys_rst_i, // sync reset
	input  wire logic        en_i,      // source running
	input  wire logic [23:0] inc_i,     // phase step per cycle
	output logic             tick_o     // one-cycle tick
);

	osc_block_pkg::tick_state_t st;
	osc_block_pkg::tick_state_t next_st;
	logic [24:0]                sum;

	// accumulate phase, tick on wrap
	always_comb begin
		sum = {1'b0, st.acc} + {1'b0, inc_i};
		next_st = st;
		next_st.tick = 1'b0;
		if (en_i) begin
			next_st.acc = sum[23:0];
			next_st.tick = sum[24];
		end else begin
			next_st.acc = 24'h000000;
		end
	end

	// state register
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_o = st.tick;

endmodule

// ### verification/osc_block_asserts.sv
`timescale 1ns/1ps
module osc_block_asserts (
	input wire logic        sys_clk_i,             // clock
	input wire logic        sys_rst_i,             // reset
	input wire logic        psel_i,                // select
	input wire logic        penable_i,             // enable
	input wire logic        pwrite_i,              // write
	input wire logic [7:0]  paddr_i,               // address
	input wire logic [31:0] prdata_o,              // read data
	input wire logic        pready_o,              // ready
	input wire logic        pslverr_o,             // error
	input wire logic [3:0]  fosc_cfg_i,            // osc config
	input wire logic        put_en_i,              // feature
	input wire logic        fscm_en_i,             // feature
	input wire logic        wdt_en_i,              // feature
	input wire logic        two_speed_en_i,        // feature
	input wire logic        port_a_bit7_drv_i,     // port drives
	input wire logic        port_a_bit6_drv_i,     // port drives
	input wire logic        osc_input_pin_oe_n_o,  // in pin oe
	input wire logic        osc_output_pin_oe_n_o, // out pin oe
	input wire logic        fast_src_en_o,         // fast on
	input wire logic        slow_src_en_o,         // slow on
	input wire logic        pll_active_o           // pll on
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	// mode decode
	logic dual;
	logic clko;
	assign dual = fosc_cfg_i == 4'h8;
	assign clko = fosc_cfg_i == 4'h9;

	////////////////////////////////////////////////////////////////////
	property p_wait;
		psel_i && penable_i && !pready_o |=> pready_o;
	endproperty
	a_wait: assert property (p_wait) else $error("ready late");
	property p_only;
		pready_o |-> $past(psel_i && penable_i);
	endproperty
	a_only: assert property (p_only) else $error("stray ready");
	property p_map;
		pready_o |-> pslverr_o == !(paddr_i inside {8'h00, 8'h04, 8'h08});
	endproperty
	a_map: assert property (p_map) else $error("bad error flag");
	property p_pllrd;
		(!(dual || clko))[*3] ##0 (pready_o && !pwrite_i && paddr_i == 8'h04)
			|-> !prdata_o[6];
	endproperty
	a_pllrd: assert property (p_pllrd) else $error("pll bit set");
	property p_slow;
		put_en_i || fscm_en_i || wdt_en_i || two_speed_en_i
			|-> ##[1:2] slow_src_en_o;
	endproperty
	a_slow: assert property (p_slow) else $error("slow rc off");
	property p_rst;
		$fell(sys_rst_i) |-> ##[0:2] fast_src_en_o;
	endproperty
	a_rst: assert property (p_rst) else $error("fast off after reset");
	property p_dual;
		(dual && port_a_bit6_drv_i && port_a_bit7_drv_i)[*3]
			|-> !osc_output_pin_oe_n_o && !osc_input_pin_oe_n_o;
	endproperty
	a_dual: assert property (p_dual) else $error("dual io not driven");
	property p_clko;
		(clko)[*3] |-> !osc_output_pin_oe_n_o;
	endproperty
	a_clko: assert property (p_clko) else $error("clkout not driven");
	property p_other;
		(!(dual || clko))[*3] |-> osc_output_pin_oe_n_o && osc_input_pin_oe_n_o;
	endproperty
	a_other: assert property (p_other) else $error("pins driven");

	// main scenarios
	c_err: cover property (pready_o && pslverr_o);
	c_pll: cover property (pll_active_o);
	c_slow: cover property ($rose(slow_src_en_o));
endmodule

// ### verification/tb_internal_oscillator_block_ctrl.sv
`timescale 1ns/1ps
module tb_internal_oscillator_block_ctrl;
	logic        sys_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [3:0]  fosc_cfg_i = 4'h9;
	logic        put_en_i = 1'b0;
	logic        fscm_en_i = 1'b0;
	logic        wdt_en_i = 1'b0;
	logic        two_speed_en_i = 1'b0;
	logic        osc_input_pin_i = 1'b0;
	logic        osc_output_pin_i = 1'b0;
	logic        port_a_bit7_dout_i = 1'b0;
	logic        port_a_bit7_drv_i = 1'b0;
	logic        port_a_bit6_dout_i = 1'b0;
	logic        port_a_bit6_drv_i = 1'b0;
	logic [31:0] prdata_o;
	logic        pready_o, pslverr_o, osc_input_pin_o, osc_output_pin_o;
	logic        osc_input_pin_oe_n_o, osc_output_pin_oe_n_o, dev_clk_o;
	logic        port_a_bit7_din_o, port_a_bit6_din_o, pll_active_o;
	logic        fast_src_en_o, slow_src_en_o;
	int          failures = 0;
	int          n_compared = 0;

	// 125 MHz clock
	always #4 sys_clk_i = ~sys_clk_i;

	internal_oscillator_block_ctrl #(.SLEW_CYC(8)) u_dut (
		.sys_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .pready_o, .prdata_o, .pslverr_o, .fosc_cfg_i, .put_en_i,
		.fscm_en_i, .wdt_en_i, .two_speed_en_i, .osc_input_pin_i,
		.osc_output_pin_i, .port_a_bit7_dout_i, .port_a_bit7_drv_i,
		.port_a_bit6_dout_i, .port_a_bit6_drv_i, .osc_input_pin_o,
		.osc_input_pin_oe_n_o, .osc_output_pin_o, .osc_output_pin_oe_n_o,
		.port_a_bit7_din_o, .port_a_bit6_din_o, .dev_clk_o, .fast_src_en_o,
		.slow_src_en_o, .pll_active_o
	);

	////////////////////////////////////////////////////////////////////
	// value compare
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, g, x);
		end
	endtask

	// one apb transfer, held until ready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (pready_o !== 1'b1) chk(32'h0, 32'h1);
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		chk(32'(e), 32'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk(32'(e), 32'h0);
	endtask

	// count dev clock and out pin rising edges over 1000 cycles
	task automatic meas(input int lo, input int hi);
		int   c;
		int   c4;
		logic p;
		logic q;
		c = 0;
		c4 = 0;
		repeat (300) @(posedge sys_clk_i);
		p = dev_clk_o;
		q = osc_output_pin_o;
		repeat (1000) begin
			@(posedge sys_clk_i);
			if (dev_clk_o === 1'b1 && p === 1'b0) c++;
			if (osc_output_pin_o === 1'b1 && q === 1'b0) c4++;
			p = dev_clk_o;
			q = osc_output_pin_o;
		end
		chk(32'(c >= lo && c <= hi), 32'h1);
		chk(32'(c4 >= lo / 4 && c4 <= (hi + 3) / 4), 32'h1);
	endtask

	task automatic wrap_up();
		$display("compared %0d failed %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// test sequence
	initial begin
		logic [31:0] r;
		logic        e;
		repeat (16) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		rd(8'h00, 32'h40);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h06);
		apb(1'b0, 8'h0c, 32'h0, r, e);
		chk({e, r[30:0]}, 32'h80000000);
		$display("reset and map test done");
		for (int i = 0; i < 8; i++) begin
			wr(8'h00, 32'(i) << 4);
			rd(8'h00, 32'(i) << 4);
			chk(32'(fast_src_en_o), 32'(i != 0));
		end
		wr(8'h00, 32'h00);
		repeat (1200) @(posedge sys_clk_i);
		chk(32'(slow_src_en_o), 32'h1);
		wr(8'h04, 32'h80);
		rd(8'h04, 32'h80);
		chk(32'(fast_src_en_o), 32'h1);
		wr(8'h04, 32'h3f);
		rd(8'h04, 32'h1f);
		$display("select test done");
		wr(8'h00, 32'h60);
		wr(8'h04, 32'h40);
		rd(8'h04, 32'h40);
		// leaving the slow rc waits for its next falling edge
		repeat (3000) @(posedge sys_clk_i);
		meas(126, 130);
		chk(32'(pll_active_o), 32'h1);
		fosc_cfg_i <= 4'h0;
		rd(8'h04, 32'h0);
		repeat (16) @(posedge sys_clk_i);
		chk(32'(dev_clk_o), 32'h0);
		wr(8'h00, 32'he2);
		rd(8'h00, 32'he2);
		wr(8'h00, 32'h60);
		wr(8'h04, 32'h40);
		fosc_cfg_i <= 4'h9;
		rd(8'h04, 32'h0);
		wr(8'h04, 32'h40);
		wr(8'h00, 32'h40);
		rd(8'h04, 32'h0);
		wr(8'h00, 32'h70);
		meas(62, 66);
		wr(8'h04, 32'h0f);
		meas(67, 100);
		wr(8'h04, 32'h00);
		wr(8'h00, 32'h40);
		meas(7, 9);
		$display("pll and rate test done");
		for (int i = 0; i < 4; i++) begin
			{put_en_i, fscm_en_i, wdt_en_i, two_speed_en_i} <= 4'(1 << i);
			repeat (3) @(posedge sys_clk_i);
			chk(32'(slow_src_en_o), 32'h1);
		end
		{put_en_i, fscm_en_i, wdt_en_i, two_speed_en_i} <= 4'h0;
		repeat (3) @(posedge sys_clk_i);
		chk(32'(slow_src_en_o), 32'h0);
		$display("feature test done");
		fosc_cfg_i <= 4'h8;
		{port_a_bit7_dout_i, port_a_bit7_drv_i} <= 2'b11;
		{port_a_bit6_dout_i, port_a_bit6_drv_i} <= 2'b01;
		osc_input_pin_i <= 1'b1;
		osc_output_pin_i <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		chk({osc_input_pin_oe_n_o, osc_output_pin_oe_n_o, osc_input_pin_o,
			osc_output_pin_o, port_a_bit7_din_o, port_a_bit6_din_o},
			6'b001011);
		fosc_cfg_i <= 4'h9;
		port_a_bit7_drv_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		chk({osc_input_pin_oe_n_o, osc_output_pin_oe_n_o}, 2'b10);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		rd(8'h00, 32'h40);
		$display("pin and reset test done");
		wrap_up();
	end

	// watchdog
	initial begin
		repeat (60000) @(posedge sys_clk_i);
		failures++;
		$display("[ERR] %0t watchdog expired", $time);
		wrap_up();
	end
endmodule

bind internal_oscillator_block_ctrl osc_block_asserts u_chk (
	.sys_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.prdata_o, .pready_o, .pslverr_o, .fosc_cfg_i, .put_en_i, .fscm_en_i,
	.wdt_en_i, .two_speed_en_i, .port_a_bit7_drv_i, .port_a_bit6_drv_i,
	.osc_input_pin_oe_n_o, .osc_output_pin_oe_n_o, .fast_src_en_o,
	.slow_src_en_o, .pll_active_o
);
